// *** src/pbd_pkg.sv ***
/*
 * Constants and bundled types for the program board address decode.
 * Assumes a single 40 MHz clock and a CPU bus that is synchronous to it.
 */
`default_nettype none
package pbd_pkg;
	localparam logic [15:0] SWITCH_BYTE_ADDR  = 16'h5000;
	localparam logic [15:0] PORT_XFER_ADDR    = 16'h4100;
	localparam logic [15:0] LATCH_A_ADDR      = 16'h4000;
	localparam logic [15:0] LATCH_B_ADDR      = 16'h4001;
	localparam logic [15:0] SERIAL_LOW_ADDR   = 16'ha008;
	localparam logic [15:0] SERIAL_HIGH_ADDR  = 16'ha009;
	localparam logic [5:0]  BANK_E_PAGE       = 6'h38;
	localparam logic [5:0]  BANK_D_PAGE       = 6'h34;
	localparam logic [4:0]  MASK_E_PAGE       = 5'h1c;
	localparam logic [8:0]  RAM_SIZE          = 9'h180;
	localparam logic [3:0]  DIGIT_BANK_8      = 4'h0;
	localparam logic [3:0]  DIGIT_BANK_B      = 4'h6;
	localparam logic [3:0]  DIGIT_BANK_C      = 4'h8;
	localparam logic [3:0]  DIGIT_RAM         = 4'h0;
	localparam int          RATE_COUNT        = 8;
	localparam int          BASE_DIV          = 16;
	localparam logic [11:0] RATE_DIV_0        = 12'h010;

	typedef struct packed {
		logic [3:0] promBank;
		logic [1:0] maskRom;
		logic       ram;
		logic       switchByte;
		logic       portXfer;
		logic       latchA;
		logic       latchB;
		logic       serial;
	} pbd_sel_t;

	typedef struct packed {
		logic [3:0] highNib;
		logic [3:0] lowNib;
	} pbd_nib_pair_t;

	typedef struct packed {
		logic [7:0] latchB;
		logic [7:0] latchA;
	} pbd_port_word_t;

	typedef struct packed {
		logic [1:0] parity;
		logic       twoStop;
		logic       speed;
	} pbd_format_t;
endpackage : pbd_pkg
`default_nettype wire

// *** src/pbd_board_decode.sv ***
/*
 * Address decode, bus glue, scratch RAM, output ports and bit-rate
 * selection of the program option board. Assumes the CPU holds address,
 * direction and data stable for the whole cycle marked by busValid.
 */
`default_nettype none
module pbd_board_decode
	import pbd_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic [15:0]   addr,
	input  wire logic [7:0]    dataIn,
	input  wire logic          rw,
	input  wire logic          busValid,
	input  wire logic          maskFit,
	input  wire logic          bank4Low,
	input  wire logic [1:0]    configRoute,
	input  wire logic          altIfaceInUse,
	input  wire pbd_format_t   configFormat,
	input  wire logic          ifaceEnableSwitch,
	input  wire logic [2:0]    bitRateSelector,
	input  wire logic [7:0]    inputConnector,
	input  wire pbd_nib_pair_t promData,
	input  wire logic [7:0]    maskData,
	input  wire logic [7:0]    serialData,
	input  wire logic          portReady,
	output pbd_sel_t           sel,
	output logic [3:0]         promPowerEn,
	output logic               byteDriverEn,
	output logic               readEnable,
	output logic [7:0]         dataOut,
	output logic               serialSel,
	output logic [1:0]         serialRegSel,
	output pbd_format_t        serialFormat,
	output logic               bitRateTick,
	output logic               portValid,
	output pbd_port_word_t     portData,
	output logic               busWait
);
	logic [9:0]     regionDecoder;
	logic           digitValid;
	logic           bankE, bankD, bankC, bankB, bank8;
	logic           ramHit, boardHit, readInhibit, ifaceOn;
	logic [8:0]     ramIndex;
	logic [7:0]     ramQ, readMux;
	logic [7:0]     scratch [384];
	logic           readEnable_reg;
	logic [7:0]     dataOut_reg;
	logic [7:0]     latchA_reg, latchB_reg;
	pbd_format_t    serialFormat_reg;
	pbd_port_word_t slot_reg [2];
	logic [1:0]     count_reg;
	logic           head_reg;
	logic           pushWord, popWord;
	logic [RATE_COUNT-1:0] rateTicks;

	// Decimal decoder ignores codes ten to fifteen, like the part it replaces
	assign digitValid = addr[14:11] < 4'ha;
	genvar d;
	generate
		for (d = 0; d < 10; d++)
		begin : g_digit
			assign regionDecoder[d] = digitValid && addr[14:11] == 4'(d);
		end
	endgenerate

	assign bank8  = addr[15] && regionDecoder[DIGIT_BANK_8] && !addr[10];
	assign bankB  = addr[15] && regionDecoder[DIGIT_BANK_B] && !addr[10];
	assign bankC  = addr[15] && regionDecoder[DIGIT_BANK_C] && !addr[10];
	assign bankD  = addr[15:10] == BANK_D_PAGE;
	assign bankE  = addr[15:10] == BANK_E_PAGE;
	assign ramIndex = addr[8:0];
	assign ramHit = !addr[15] && regionDecoder[DIGIT_RAM]
		&& addr[10:9] == 2'b00 && ramIndex < RAM_SIZE;
	assign ifaceOn = ifaceEnableSwitch;

	// Each select is an exact, disjoint region, so only one can be active
	always_comb
	begin
		sel = '0;
		if (busValid)
		begin
			sel.promBank[0] = !maskFit && bankE;
			sel.promBank[1] = !maskFit && bankD;
			sel.promBank[2] = !maskFit && bankC;
			sel.promBank[3] = !maskFit && (bank4Low ? bank8 : bankB);
			sel.maskRom[0] = maskFit && addr[15:11] == MASK_E_PAGE;
			sel.maskRom[1] = maskFit && (bankD || bank8);
			sel.ram        = ramHit;
			sel.switchByte = addr == SWITCH_BYTE_ADDR;
			sel.portXfer   = addr == PORT_XFER_ADDR;
			sel.latchA     = addr == LATCH_A_ADDR;
			sel.latchB     = addr == LATCH_B_ADDR;
			sel.serial     = ifaceOn && (addr == SERIAL_LOW_ADDR
				|| addr == SERIAL_HIGH_ADDR);
		end
	end

	// Bank power follows the select, not a register, so it never lags
	assign promPowerEn  = sel.promBank;
	assign serialSel    = sel.serial;
	assign serialRegSel = {addr[3], addr[0]} & {2{sel.serial}};
	assign byteDriverEn = sel.ram && !rw;

	assign readInhibit = configRoute != 2'b00 && altIfaceInUse;
	assign boardHit = |sel.promBank || |sel.maskRom || sel.ram
		|| sel.switchByte || sel.serial;
	assign ramQ = ramHit ? scratch[ramIndex] : 8'h00;

	always_comb
	begin
		readMux = 8'h00;
		if (|sel.promBank)
			readMux = {promData.highNib, promData.lowNib};
		else if (|sel.maskRom)
			readMux = maskData;
		else if (sel.ram)
			readMux = ramQ;
		else if (sel.switchByte)
			readMux = inputConnector;
		else if (sel.serial)
			readMux = serialData;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			readEnable_reg <= 1'b0;
		else
			readEnable_reg <= rw && boardHit && !readInhibit;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			dataOut_reg <= 8'h00;
		else if (rw && boardHit)
			dataOut_reg <= readMux;
	end

	assign readEnable = readEnable_reg;
	assign dataOut    = dataOut_reg;

	// Scratch RAM has no reset: contents are undefined at power up
	always_ff @(posedge clock)
	begin
		if (byteDriverEn)
			scratch[ramIndex] <= dataIn;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			latchA_reg <= 8'h00;
			latchB_reg <= 8'h00;
		end
		else if (!rw && sel.latchA)
			latchA_reg <= dataIn;
		else if (!rw && sel.latchB)
			latchB_reg <= dataIn;
	end

	// Two-entry buffer; a full buffer holds the CPU through busWait
	assign pushWord = !rw && sel.portXfer && count_reg != 2'd2;
	assign popWord  = portValid && portReady;
	assign busWait  = sel.portXfer && !rw && count_reg == 2'd2;
	assign portValid = count_reg != 2'd0;
	assign portData  = slot_reg[head_reg];

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg <= 2'd0;
			head_reg  <= 1'b0;
			slot_reg[0] <= '0;
			slot_reg[1] <= '0;
		end
		else
		begin
			if (pushWord)
				slot_reg[head_reg ^ count_reg[0]] <= {latchB_reg, latchA_reg};
			if (popWord)
				head_reg <= !head_reg;
			count_reg <= count_reg + 2'(pushWord) - 2'(popWord);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			serialFormat_reg <= '0;
		else if (ifaceOn)
			serialFormat_reg <= configFormat;
	end
	assign serialFormat = serialFormat_reg;

	// Each rate halves the one before; a separate counter per rate
	genvar r;
	generate
		for (r = 0; r < RATE_COUNT; r++)
		begin : g_rate
			logic [18:0] div_reg;
			localparam logic [18:0] LIMIT = 19'(BASE_DIV << r) - 19'd1;
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
					div_reg <= '0;
				else if (div_reg == LIMIT)
					div_reg <= '0;
				else
					div_reg <= div_reg + 19'd1;
			end
			assign rateTicks[r] = div_reg == LIMIT;
		end
	endgenerate

	assign bitRateTick = ifaceOn && rateTicks[bitRateSelector];

	onehot_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
		$onehot0(sel)) else $error("two selects active");
	read_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		readEnable |-> $past(rw && boardHit && !readInhibit))
		else $error("read buffer on without decoded read");
	alt_inhibit_a: assert property (@(posedge clock) disable iff (!rst_n)
		readInhibit |=> !readEnable)
		else $error("read buffer drove during alternate use");
	serial_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
		serialSel |-> ifaceEnableSwitch && addr[15:1] == 15'h5004)
		else $error("serial select at wrong address");
	power_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
		promPowerEn == sel.promBank && $countones(promPowerEn) <= 1)
		else $error("bank power not following select");
	driver_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
		byteDriverEn |-> !rw && addr < 16'h0180)
		else $error("byte drivers on outside RAM write");
	ram_echo_a: assert property (@(posedge clock) disable iff (!rst_n)
		busValid && ramHit && !rw ##1 !busValid ##1 busValid && rw
		&& ramHit && addr == $past(addr, 2)
		|=> dataOut == $past(dataIn, 3))
		else $error("RAM read does not return written byte");
	switch_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
		sel.switchByte && rw |=> dataOut == $past(inputConnector))
		else $error("switch byte not gated");
	port_xfer_a: assert property (@(posedge clock) disable iff (!rst_n)
		pushWord && count_reg == 2'd0 |=> portValid
		&& portData == $past({latchB_reg, latchA_reg}))
		else $error("output latches not transferred");
	rate_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ifaceEnableSwitch |-> !bitRateTick)
		else $error("bit rate while interface off");

	ram_write_c: cover property (@(posedge clock) byteDriverEn);
	prom_read_c: cover property (@(posedge clock) readEnable ##2 readEnable);
	port_full_c: cover property (@(posedge clock) busWait);
	serial_reg_c: cover property (@(posedge clock) serialRegSel == 2'b11);
endmodule : pbd_board_decode
`default_nettype wire

// *** dv/pbd_cpu_model.sv ***
/*
 * CPU board model: runs one bus cycle for each call of cyc and records
 * what the board shows while the cycle is taken and on the read answer.
 * Assumes the board registers its answer on the same rising edge that takes the cycle.
 */
`default_nettype none
module pbd_cpu_model
	import pbd_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       busWait,
	input  wire pbd_sel_t   sel,
	input  wire logic [3:0] promPowerEn,
	input  wire logic       byteDriverEn,
	input  wire logic       serialSel,
	input  wire logic [1:0] serialRegSel,
	input  wire logic       readEnable,
	input  wire logic [7:0] dataOut,
	output logic [15:0]     addr,
	output logic [7:0]      dataIn,
	output logic            rw,
	output logic            busValid
);
	timeunit 1ns;
	timeprecision 1ps;
	pbd_sel_t   selSeen;
	logic [7:0] misc;
	logic       reSeen;
	logic [7:0] doSeen;
	logic       hung;
	initial
	begin
		addr = 16'h0000;
		dataIn = 8'h00;
		rw = 1'b1;
		busValid = 1'b0;
		hung = 1'b0;
	end
	task cyc(input logic [15:0] a, input logic r, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		addr <= a;
		rw <= r;
		dataIn <= d;
		busValid <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (busWait && n < 64);
		// Refused cycles are held whole until the board takes them or 64 clocks pass
		hung = busWait;
		selSeen = sel;
		misc = {promPowerEn, byteDriverEn, serialSel, serialRegSel};
		// Released lines show the inverse so stale values cannot match
		busValid <= 1'b0;
		addr <= ~a;
		rw <= ~r;
		dataIn <= ~d;
		@(negedge clock);
		reSeen = readEnable;
		doSeen = dataOut;
	endtask : cyc
endmodule : pbd_cpu_model
`default_nettype wire

// *** dv/pbd_board_decode_tb.sv ***
/*
 * Self-checking bench for the board decode: one task per scenario.
 * Assumes the CPU model in pbd_cpu_model and the shared package.
 */
`default_nettype none
module pbd_board_decode_tb
	import pbd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, rw, busValid, maskFit, bank4Low, altIfaceInUse;
	logic ifaceEnableSwitch, portReady, byteDriverEn, readEnable;
	logic serialSel, bitRateTick, portValid, busWait;
	logic [15:0] addr;
	logic [7:0] dataIn, inputConnector, maskData, serialData, dataOut;
	logic [1:0] configRoute, serialRegSel;
	logic [2:0] bitRateSelector;
	logic [3:0] promPowerEn;
	pbd_format_t configFormat, serialFormat;
	pbd_nib_pair_t promData;
	pbd_sel_t sel;
	pbd_port_word_t portData;
	int badCount, checksDone;
	always #12.5 clock = ~clock;
	pbd_board_decode dut (.clock(clock), .rst_n(rst_n), .addr(addr),
		.dataIn(dataIn), .rw(rw), .busValid(busValid), .maskFit(maskFit),
		.bank4Low(bank4Low), .configRoute(configRoute),
		.altIfaceInUse(altIfaceInUse), .configFormat(configFormat),
		.ifaceEnableSwitch(ifaceEnableSwitch),
		.bitRateSelector(bitRateSelector), .inputConnector(inputConnector),
		.promData(promData), .maskData(maskData), .serialData(serialData),
		.portReady(portReady), .sel(sel), .promPowerEn(promPowerEn),
		.byteDriverEn(byteDriverEn), .readEnable(readEnable),
		.dataOut(dataOut), .serialSel(serialSel),
		.serialRegSel(serialRegSel), .serialFormat(serialFormat),
		.bitRateTick(bitRateTick), .portValid(portValid),
		.portData(portData), .busWait(busWait));
	pbd_cpu_model cpu (.clock(clock), .busWait(busWait), .sel(sel),
		.promPowerEn(promPowerEn), .byteDriverEn(byteDriverEn),
		.serialSel(serialSel), .serialRegSel(serialRegSel),
		.readEnable(readEnable), .dataOut(dataOut), .addr(addr),
		.dataIn(dataIn), .rw(rw), .busValid(busValid));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task limit(input logic hit);
		if (hit)
		begin
			badCount++;
			tally_and_finish();
		end
	endtask : limit
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checksDone++;
		if (s !== e)
		begin
			badCount++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task bus(input logic [15:0] a, input logic r, input logic [7:0] d);
		cpu.cyc(a, r, d);
		limit(cpu.hung);
	endtask : bus
	task ram_t;
		bus(16'h017f, 1'b0, 8'h5a);
		chk("driver", 16'h1, 16'(cpu.misc[3]));
		bus(16'h0000, 1'b0, 8'ha5);
		bus(16'h0000, 1'b1, 8'h00);
		chk("ram", 16'h1a5, {cpu.reSeen, cpu.doSeen});
		chk("nodrv", 16'h0, 16'(cpu.misc[3]));
		bus(16'h017f, 1'b1, 8'h00);
		chk("ram", 16'h15a, {cpu.reSeen, cpu.doSeen});
	endtask : ram_t
	task decode_t;
		logic [15:0] at [9] = '{16'he3ff, 16'hd000, 16'hc3ff, 16'hb000,
			16'h8000, 16'h6000, 16'he7ff, 16'hd000, 16'h8000};
		logic [11:0] es [9] = '{12'h100, 12'h200, 12'h400, 12'h800,
			12'h800, 12'h000, 12'h040, 12'h080, 12'h080};
		logic [8:0] ed [9] = '{9'h1c3, 9'h1c3, 9'h1c3, 9'h1c3, 9'h1c3,
			9'h0c3, 9'h196, 9'h196, 9'h196};
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clock);
			bank4Low <= (i == 4);
			maskFit <= (i > 5);
			bus(at[i], 1'b1, 8'h00);
			chk("sel", 16'(es[i]), 16'(cpu.selSeen));
			chk("power", 16'(es[i][11:8]), 16'(cpu.misc[7:4]));
			chk("rd", 16'(ed[i]), {cpu.reSeen, cpu.doSeen});
		end
	endtask : decode_t
	task sw_t;
		bus(16'h5000, 1'b1, 8'h00);
		chk("swsel", 16'h010, 16'(cpu.selSeen));
		chk("swrd", 16'h1a5, {cpu.reSeen, cpu.doSeen});
	endtask : sw_t
	task ser_t;
		@(posedge clock);
		ifaceEnableSwitch <= 1'b1;
		configFormat <= 4'h9;
		bus(16'ha008, 1'b1, 8'h00);
		chk("reg", 16'h6, 16'(cpu.misc[2:0]));
		bus(16'ha009, 1'b1, 8'h00);
		chk("reg", 16'h7, 16'(cpu.misc[2:0]));
		chk("fmt", 16'h9, 16'(serialFormat));
		@(posedge clock);
		ifaceEnableSwitch <= 1'b0;
		configFormat <= 4'h6;
		bus(16'ha008, 1'b1, 8'h00);
		chk("off", 16'h0, 16'(cpu.misc[2]));
		chk("fmt", 16'h9, 16'(serialFormat));
	endtask : ser_t
	task inh_t;
		@(posedge clock);
		configRoute <= 2'b01;
		altIfaceInUse <= 1'b1;
		bus(16'h0000, 1'b1, 8'h00);
		chk("inhibit", 16'h0, 16'(cpu.reSeen));
		@(posedge clock);
		altIfaceInUse <= 1'b0;
		bus(16'h0000, 1'b1, 8'h00);
		chk("inhibit", 16'h1, 16'(cpu.reSeen));
	endtask : inh_t
	task port_t;
		int n;
		bus(16'h4000, 1'b0, 8'h11);
		bus(16'h4001, 1'b0, 8'h22);
		bus(16'h4100, 1'b0, 8'h00);
		bus(16'h4000, 1'b0, 8'h33);
		bus(16'h4100, 1'b0, 8'h00);
		chk("head", 16'h2211, portData);
		fork
			bus(16'h4100, 1'b0, 8'h00);
			begin
				@(posedge clock);
				@(negedge clock);
				chk("wait", 16'h1, 16'(busWait));
				@(posedge clock);
				portReady <= 1'b1;
			end
		join
		n = 0;
		while (portValid && n < 20)
		begin
			@(negedge clock);
			n++;
		end
		limit(n >= 20);
	endtask : port_t
	task rate_t;
		int n;
		for (int r = 0; r < 2; r++)
		begin
			@(posedge clock);
			ifaceEnableSwitch <= 1'b1;
			bitRateSelector <= 3'(r);
			for (int k = 0; k < 2; k++)
			begin
				n = 0;
				do
				begin
					@(negedge clock);
					n++;
				end
				while (!bitRateTick && n < 300);
				limit(n >= 300);
			end
			chk("rate", 16'(16 << r), 16'(n));
		end
	endtask : rate_t
	initial
	begin
		{clock, rst_n, maskFit, bank4Low, altIfaceInUse} = '0;
		{ifaceEnableSwitch, portReady, configRoute, bitRateSelector} = '0;
		{badCount, checksDone} = '0;
		configFormat = 4'h0;
		inputConnector = 8'ha5;
		promData = 8'hc3;
		maskData = 8'h96;
		serialData = 8'he1;
		repeat (4) @(posedge clock);
		chk("reset", 16'h0, {readEnable, portValid, dataOut});
		rst_n <= 1'b1;
		ram_t();
		decode_t();
		sw_t();
		ser_t();
		inh_t();
		port_t();
		rate_t();
		tally_and_finish();
	end
endmodule : pbd_board_decode_tb
`default_nettype wire
